// [psm_pkg.sv]
package psm_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [3:0] OFF_PWR_CTRL  = 4'h0;  // power_control_reg
    localparam logic [3:0] OFF_WAKE_CTRL = 4'h4;  // wakeup_control_reg
    localparam logic [3:0] OFF_SYS_CTRL  = 4'h8;  // system_control_reg
    localparam logic [3:0] OFF_STATUS    = 4'hc;  // mode status

    // power_control_reg fields
    localparam int BIT_IDLE_EN  = 0;
    localparam int BIT_PD_EN    = 1;
    localparam int BIT_GF0      = 2;
    localparam int BIT_GF1      = 3;
    localparam int BIT_SLOWDOWN = 4;
    localparam int BIT_IDLE_ST  = 5;
    localparam int BIT_PD_ST    = 6;
    // wakeup_control_reg fields
    localparam int BIT_WS       = 4;
    localparam int BIT_EXT_WAKEUP_ENABLE     = 7;
    // system_control_reg fields
    localparam int BIT_MAP_SEL  = 4;

    localparam logic [7:0] PWR_CTRL_RST  = 8'h00;
    localparam logic       WS_RST        = 1'b0;
    localparam logic       EXT_WAKEUP_ENABLE_RST      = 1'b0;
    localparam logic [7:0] SYS_CTRL_RST  = 8'h00;

    // timing
    localparam int CLK_MHZ         = 50;
    localparam int SLOW_DIV        = 32;
    localparam int MC_CLKS         = 12;      // clocks per machine cycle
    localparam int RST_HOLD_MC     = 2;
    localparam int WAKE_LOW_NS     = 10000;   // 10 us
    localparam int RC_CLK_NS       = 20;      // rc timebase period
    localparam int WAKE_LOW_CNT    = (WAKE_LOW_NS + RC_CLK_NS - 1) / RC_CLK_NS;
    localparam logic [15:0] WAKE_VECTOR = 16'h007b;

    typedef enum logic [5:0] {
        ST_RUN     = 6'h01,
        ST_IDLE    = 6'h02,
        ST_PD      = 6'h04,
        ST_OSC     = 6'h08,
        ST_WAKE_IRQ= 6'h10,
        ST_WAKE_SVC= 6'h20
    } pm_state_t;

endpackage

// [wake_qual_if.sv]
`timescale 1ns/100ps
interface wake_qual_if;
    logic arm;     // counting allowed (power-down)
    logic pin_low; // synchronised selected pin is low
    logic done;    // low time qualified
    modport master (output arm, output pin_low, input done);
    modport slave  (input arm, input pin_low, output done);
endinterface

// [wake_qual.sv]
`timescale 1ns/100ps
module wake_qual
    import psm_pkg::*;
#(
    parameter int LOW_CNT = WAKE_LOW_CNT
) (
    input  wire logic       i_rc_clk,  // free-running rc timebase
    input  wire logic       i_rst_b,   // synchronous reset, active low
    wake_qual_if.slave      q          // qualifier handshake
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
        logic [1:0]  arm_s;
        logic [1:0]  low_s;
    } wq_t;
    wq_t s_r, s_nxt;

    // counts on rc clock, independent of stopped crystal
    always_comb begin
        s_nxt = s_r;
        // mclk-side levels brought into the rc domain
        s_nxt.arm_s = {s_r.arm_s[0], q.arm};
        s_nxt.low_s = {s_r.low_s[0], q.pin_low};
        if (!s_r.arm_s[1] || !s_r.low_s[1]) begin
            s_nxt.cnt  = 16'h0000;
            s_nxt.done = 1'b0;
        end else if (s_r.cnt >= 16'(LOW_CNT - 1)) begin
            s_nxt.done = 1'b1;                                  // see RL27
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_rc_clk) begin
        if (!i_rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q.done = s_r.done;
endmodule

// [power_saving_mode_control.sv]
`timescale 1ns/100ps
// How it works
// RL1: software writes idle enable, then idle start
// RL2: idle entered right after idle-start write
// RL3: enabled interrupt ends idle, execution resumes
// RL4: two machine cycle reset suffices in idle
// RL5: slow-down divides all derived clocks by 32
// RL6: slow-down active within two machine cycles
// RL7: combined idle: enable, then start plus slow-down
// RL8: slow-down bit stays set after idle exit
// RL9: power-down stops both oscillators, state kept
// RL10: power-down: strobes low, outputs held
// RL11: reset exit restores registers, restarts oscillators
// RL12: power-down needs enable then start write
// RL13: enable and start bits self-clear, read zero
// RL14: no wake enable: only reset leaves power-down
// RL15: software sets wake enable via mapped select
// RL16: wake enable globally masks all interrupts
// RL17: wake source select picks alternate receive pin
// RL18: wake pin low 10 us ends power-down
// RL19: stable crystal resumes at vector 007b
// RL20: timers frozen until wake handler returns
// RL21: interrupts blocked until wake handler returns
// RL22: software stops conversion before power-down
// RL23: idle enable bit 0, idle start bit 5
// RL24: idle gates cpu clock, peripherals keep running
// RL25: power-down wins over simultaneous idle
// RL26: wake source select resets to zero
// RL27: wake low time timed by rc timebase
module power_saving_mode_control
    import psm_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_LOW_CNT
) (
    input  wire logic        i_mclk,           // system clock, 50 MHz
    input  wire logic        i_rst_b,          // synchronous reset, active low
    input  wire logic        i_rc_clk,         // rc oscillator timebase
    // avalon-mm slave
    input  wire logic [3:0]  i_address,        // byte address
    input  wire logic        i_read,           // read request
    input  wire logic        i_write,          // write request
    input  wire logic [31:0] i_writedata,      // write data
    input  wire logic [3:0]  i_byteenable,     // byte lanes
    output logic      [31:0] o_readdata,       // read data
    output logic             o_waitrequest,    // stall
    output logic             o_response_err,   // unmapped access
    // cpu and interrupt side
    input  wire logic        i_irq_pending,    // any enabled interrupt pending
    input  wire logic        i_irq_return,     // interrupt_return_instr executed
    input  wire logic        i_osc_stable,     // crystal stable per osc watchdog
    input  wire logic        i_ext_int_zero_pin,      // wake pin 0
    input  wire logic        i_alt_serial_receive_pin, // alternate wake pin
    input  wire logic        i_powersave_enable_pin_b, // low allows power saving
    output logic             o_cpu_clk_en,     // cpu clock gate
    output logic             o_periph_clk_en,  // peripheral clock gate
    output logic             o_slow_tick,      // derived clock enable
    output logic             o_clock_output_pin, // clock output
    output logic             o_osc_run,        // oscillators enabled
    output logic             o_irq_global_en,  // global interrupt permission
    output logic             o_wake_irq,       // wake-up interrupt request
    output logic      [15:0] o_wake_vector,    // wake interrupt address
    output logic             o_timers_frozen,  // timers, serial, can, watchdog
    output logic             o_watchdog_run,   // watchdog_timer_unit clock
    output logic             o_strobes_low,    // ale and program_fetch_strobe low
    output logic             o_port_hold,      // hold alternate outputs
    output logic             o_wake_latched,   // latched wake pin state
    output logic             o_reset_req       // internal reset request
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        pm_state_t   st;
        logic [7:0]  power_control_reg;
        logic        ext_wakeup_enable;
        logic        ws;
        logic [7:0]  sysc;
        logic        idle_armed;
        logic        pd_armed;
        logic        sd_act;
        logic [6:0]  sd_sync;
        logic [4:0]  div;
        logic        tick;
        logic        clk_out;
        logic [1:0]  done_s;
        logic [1:0]  pse_s;
        logic        rst_req;
        logic        wake_pin_l;
        logic [31:0] rdata;
        logic        ack;
        logic        err;
        logic [1:0]  pin_s0;
        logic [1:0]  pin_s1;
        logic [1:0]  stab_s;
    } psm_t;
    psm_t s_r, s_nxt;

    wake_qual_if wq ();

    function automatic logic is_st(input pm_state_t a, input pm_state_t b);
        return a == b;
    endfunction

    logic sel_pin;
    logic access;
    logic wr_power_control_reg;
    logic [7:0] wb;

    assign access  = (i_read || i_write) && !s_r.ack;
    assign wr_power_control_reg = access && i_write && i_address == OFF_PWR_CTRL && i_byteenable[0];
    assign wb      = i_writedata[7:0];
    // see RL17
    assign sel_pin = s_r.ws ? s_r.pin_s1[1] : s_r.pin_s1[0];

    assign wq.arm     = is_st(s_r.st, ST_PD) && s_r.ext_wakeup_enable;
    assign wq.pin_low = !sel_pin;

    wake_qual #(
        .LOW_CNT (WAKE_CNT)
    ) u_wake_qual (
        .i_rc_clk (i_rc_clk),
        .i_rst_b  (i_rst_b),
        .q        (wq)
    );

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.pin_s0 = {i_alt_serial_receive_pin, i_ext_int_zero_pin};
        s_nxt.pin_s1 = s_r.pin_s0;
        s_nxt.stab_s = {s_r.stab_s[0], i_osc_stable};
        // rc-domain done and powersave enable pin level, two flops each
        s_nxt.done_s = {s_r.done_s[0], wq.done};
        s_nxt.pse_s  = {s_r.pse_s[0], i_powersave_enable_pin_b};
        s_nxt.ack    = 1'b0;
        s_nxt.err    = 1'b0;
        s_nxt.rst_req = 1'b0;

        // bus
        if (access) begin
            s_nxt.ack = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            case (i_address)
                OFF_PWR_CTRL: begin
                    // enable and start bits always read zero, see RL13
                    s_nxt.rdata[7:0] = s_r.power_control_reg & 8'h1c;
                end
                OFF_WAKE_CTRL: begin
                    s_nxt.rdata[BIT_EXT_WAKEUP_ENABLE] = s_r.ext_wakeup_enable;
                    s_nxt.rdata[BIT_WS]   = s_r.ws;
                end
                OFF_SYS_CTRL:  s_nxt.rdata[7:0] = s_r.sysc;
                OFF_STATUS:    s_nxt.rdata[5:0] = s_r.st;
                default:       s_nxt.err = 1'b1;
            endcase
            if (i_write && i_byteenable[0]) begin
                case (i_address)
                    OFF_PWR_CTRL: begin
                        s_nxt.power_control_reg[BIT_GF0]      = wb[BIT_GF0];
                        s_nxt.power_control_reg[BIT_GF1]      = wb[BIT_GF1];
                        s_nxt.power_control_reg[BIT_SLOWDOWN] = wb[BIT_SLOWDOWN];
                    end
                    OFF_WAKE_CTRL: begin
                        // mapped area only writable with select set, see RL15
                        if (s_r.sysc[BIT_MAP_SEL]) begin
                            s_nxt.ext_wakeup_enable = wb[BIT_EXT_WAKEUP_ENABLE];
                            s_nxt.ws   = wb[BIT_WS];
                        end
                    end
                    OFF_SYS_CTRL: s_nxt.sysc = wb;
                    default: ;
                endcase
            end
        end

        // two-write sequences; both bits together arm nothing
        if (wr_power_control_reg && is_st(s_r.st, ST_RUN)) begin
            s_nxt.idle_armed = wb[BIT_IDLE_EN] && !wb[BIT_IDLE_ST];   // see RL23
            s_nxt.pd_armed   = wb[BIT_PD_EN] && !wb[BIT_PD_ST];       // see RL12
            if (s_r.pse_s[1]) begin
                s_nxt.idle_armed = 1'b0;
                s_nxt.pd_armed   = 1'b0;
            end
            if (s_r.pd_armed && wb[BIT_PD_ST] && !wb[BIT_PD_EN]
                    && !s_r.pse_s[1]) begin
                s_nxt.st = ST_PD;                                     // see RL25
            end else if (s_r.idle_armed && wb[BIT_IDLE_ST] && !wb[BIT_IDLE_EN]
                    && !s_r.pse_s[1]) begin
                s_nxt.st = ST_IDLE;                                   // see RL2
            end
        end

        // mode machine
        case (s_r.st)
            ST_RUN: ;
            ST_IDLE: begin
                if (i_irq_pending) begin
                    s_nxt.st = ST_RUN;                                // see RL3
                end
            end
            ST_PD: begin
                // only wake path is qualified pin low, see RL14
                if (s_r.done_s[1] && s_r.ext_wakeup_enable) begin
                    s_nxt.st = ST_OSC;                                // see RL18
                    s_nxt.wake_pin_l = sel_pin;
                end
            end
            ST_OSC: begin
                if (s_r.stab_s[1]) begin
                    s_nxt.st = ST_WAKE_IRQ;                           // see RL19
                end
            end
            ST_WAKE_IRQ: s_nxt.st = ST_WAKE_SVC;
            ST_WAKE_SVC: begin
                if (i_irq_return) begin
                    s_nxt.st = ST_RUN;                                // see RL20
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase

        // slow-down sync at machine cycle boundary, see RL6
        s_nxt.sd_sync = s_r.sd_sync + 7'h01;
        if (s_r.sd_sync >= 7'(MC_CLKS - 1)) begin
            s_nxt.sd_sync = 7'h00;
            s_nxt.sd_act  = s_r.power_control_reg[BIT_SLOWDOWN];                  // see RL8
        end

        // divided clock enable, see RL5
        s_nxt.tick = 1'b1;
        if (s_r.sd_act) begin
            s_nxt.div  = s_r.div + 5'h01;
            s_nxt.tick = s_r.div == 5'(SLOW_DIV - 1);
        end else begin
            s_nxt.div = 5'h00;
        end
        if (s_nxt.tick && !is_st(s_r.st, ST_PD)) begin
            s_nxt.clk_out = !s_r.clk_out;
        end

    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            // registers to reset state, ram untouched, see RL11
            s_r          <= '0;
            s_r.st       <= ST_RUN;
            s_r.power_control_reg     <= PWR_CTRL_RST;
            s_r.ws       <= WS_RST;                                   // see RL26
            s_r.ext_wakeup_enable     <= EXT_WAKEUP_ENABLE_RST;
            s_r.sysc     <= SYS_CTRL_RST;
            s_r.pin_s0   <= 2'h3;
            s_r.pin_s1   <= 2'h3;
            s_r.wake_pin_l <= 1'b1;
            s_r.rst_req  <= 1'b1;                                     // see RL4
        end else begin
            s_r <= s_nxt;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    logic in_pd;
    assign in_pd = is_st(s_r.st, ST_PD);

    assign o_readdata      = s_r.rdata;
    assign o_waitrequest   = (i_read || i_write) && !s_r.ack;
    assign o_response_err  = s_r.err;
    // cpu gated in idle, peripherals run, see RL24
    assign o_cpu_clk_en    = s_r.tick && !is_st(s_r.st, ST_IDLE) && !in_pd
                             && !is_st(s_r.st, ST_OSC);
    assign o_periph_clk_en = s_r.tick && !in_pd && !is_st(s_r.st, ST_OSC);
    assign o_slow_tick     = s_r.tick;
    assign o_clock_output_pin = s_r.clk_out;
    assign o_osc_run       = !in_pd;                                  // see RL9
    assign o_irq_global_en = !s_r.ext_wakeup_enable && is_st(s_r.st, ST_RUN)       // see RL16
                             || !s_r.ext_wakeup_enable && is_st(s_r.st, ST_IDLE);
    assign o_wake_irq      = is_st(s_r.st, ST_WAKE_IRQ);
    assign o_wake_vector   = WAKE_VECTOR;
    // frozen and interrupts blocked from power-down entry to return, see RL21
    assign o_timers_frozen = in_pd || is_st(s_r.st, ST_OSC)
                             || is_st(s_r.st, ST_WAKE_IRQ) || is_st(s_r.st, ST_WAKE_SVC);
    assign o_watchdog_run  = is_st(s_r.st, ST_RUN) && s_r.tick;
    assign o_strobes_low   = in_pd;                                   // see RL10
    assign o_port_hold     = in_pd;
    assign o_wake_latched  = s_r.wake_pin_l;
    assign o_reset_req     = s_r.rst_req;

endmodule

// [psm_assertions.sv]
`timescale 1ns/100ps
module psm_checker
    import psm_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_LOW_CNT
) (
    input wire logic        i_mclk,          // system clock
    input wire logic        i_rst_b,         // reset, active low
    input wire logic [3:0]  i_address,       // byte address
    input wire logic        i_read,          // read request
    input wire logic        i_write,         // write request
    input wire logic [31:0] o_readdata,      // read data
    input wire logic        o_waitrequest,   // stall
    input wire logic        o_cpu_clk_en,    // cpu clock gate
    input wire logic        o_periph_clk_en, // peripheral clock gate
    input wire logic        o_osc_run,       // oscillators on
    input wire logic        o_irq_global_en, // interrupt permission
    input wire logic        o_wake_irq,      // wake interrupt
    input wire logic [15:0] o_wake_vector,   // wake address
    input wire logic        o_timers_frozen, // timers held
    input wire logic        o_watchdog_run,  // watchdog clock
    input wire logic        o_strobes_low,   // strobes low
    input wire logic        o_port_hold      // outputs held
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // ****************************************
    // mode and bus properties
    // ****************************************
    AST_WAIT_ONE: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");
    AST_POWER_CONTROL_REG_ZERO: assert property (
        i_read && !o_waitrequest && i_address == OFF_PWR_CTRL
        |-> o_readdata[6:5] == 2'h0 && o_readdata[1:0] == 2'h0) else $error("start bits read one");
    AST_PD_HALT: assert property (
        !o_osc_run |-> o_strobes_low && o_port_hold && o_timers_frozen)
        else $error("power-down outputs wrong");
    AST_PD_NO_IRQ: assert property (!o_osc_run |-> !o_irq_global_en)
        else $error("interrupts open in power-down");
    AST_VECTOR: assert property (o_wake_irq |-> o_wake_vector == 16'h007b)
        else $error("wrong wake vector");
    AST_WAKE_PULSE: assert property (o_wake_irq |=> !o_wake_irq)
        else $error("wake request too long");
    AST_WAKE_FROZEN: assert property (
        o_wake_irq |-> (o_timers_frozen && !o_irq_global_en)[*2]) else $error("wake not frozen");
    AST_IDLE_WD: assert property (
        !o_cpu_clk_en && o_periph_clk_en |-> !o_watchdog_run) else $error("watchdog runs idle");
    AST_PD_ENTRY: assert property (
        $fell(o_osc_run) |-> $past(i_write) || $past(i_write, 2)) else $error("stray stop");
endmodule
bind power_saving_mode_control psm_checker #(.WAKE_CNT(WAKE_CNT)) chk_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_osc_run(o_osc_run),
    .o_irq_global_en(o_irq_global_en), .o_wake_irq(o_wake_irq), .o_wake_vector(o_wake_vector),
    .o_timers_frozen(o_timers_frozen), .o_watchdog_run(o_watchdog_run),
    .o_strobes_low(o_strobes_low), .o_port_hold(o_port_hold)
);

// [cpu_side_model.sv]
`timescale 1ns/100ps
module cpu_side_model #(
    parameter int OSC_DLY = 40,
    parameter int RET_DLY = 10
) (
    input  wire logic i_mclk,        // system clock
    input  wire logic i_drop_pin,    // pull wake pin low
    input  wire logic i_raise_irq,   // raise an enabled interrupt
    input  wire logic i_osc_run,     // oscillators enabled
    input  wire logic i_wake_irq,    // wake interrupt taken
    output logic      o_pin,         // wake pin level
    output logic      o_osc_stable,  // crystal stable
    output logic      o_irq_return,  // handler return pulse
    output logic      o_irq_pending  // interrupt pending
);
    int osc_cnt = 0;
    int ret_cnt = 0;
    initial begin
        o_pin = 1'b1;
        o_osc_stable = 1'b0;
        o_irq_return = 1'b0;
        o_irq_pending = 1'b0;
    end
    always @(posedge i_mclk) begin
        o_pin <= !i_drop_pin;
        o_irq_pending <= i_raise_irq;
        osc_cnt <= !i_osc_run ? 0 : (osc_cnt < OSC_DLY ? osc_cnt + 1 : osc_cnt);
        o_osc_stable <= i_osc_run && osc_cnt == OSC_DLY;
        ret_cnt <= i_wake_irq ? 1 : (ret_cnt == RET_DLY || ret_cnt == 0 ? 0 : ret_cnt + 1);
        o_irq_return <= ret_cnt == RET_DLY;
    end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import psm_pkg::*;
;
    logic i_mclk = 1'b0, i_rc_clk = 1'b0, i_rst_b = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [3:0] i_address = 4'h0;
    logic [31:0] i_writedata = 32'h0, o_readdata;
    logic drop_pin = 1'b0, raise_irq = 1'b0, pin, stable, ret, pend;
    logic psb = 1'b0, cko, rst_req;
    logic o_waitrequest, o_response_err, o_cpu_clk_en, o_periph_clk_en, o_slow_tick, o_osc_run;
    logic o_irq_global_en, o_wake_irq, o_timers_frozen, o_watchdog_run, o_strobes_low;
    logic o_port_hold, o_wake_latched;
    logic [15:0] o_wake_vector;
    int err_count = 0, n_checks = 0;
    always #10 i_mclk = ~i_mclk;
    initial begin
        #3;
        forever #10 i_rc_clk = ~i_rc_clk;
    end
    power_saving_mode_control #(.WAKE_CNT(5)) dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_rc_clk(i_rc_clk), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'h1),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_response_err(o_response_err),
        .i_irq_pending(pend), .i_irq_return(ret), .i_osc_stable(stable),
        .i_ext_int_zero_pin(pin), .i_alt_serial_receive_pin(1'b1),
        .i_powersave_enable_pin_b(psb), .o_cpu_clk_en(o_cpu_clk_en),
        .o_periph_clk_en(o_periph_clk_en), .o_slow_tick(o_slow_tick), .o_clock_output_pin(cko),
        .o_osc_run(o_osc_run), .o_irq_global_en(o_irq_global_en), .o_wake_irq(o_wake_irq),
        .o_wake_vector(o_wake_vector), .o_timers_frozen(o_timers_frozen),
        .o_watchdog_run(o_watchdog_run), .o_strobes_low(o_strobes_low),
        .o_port_hold(o_port_hold), .o_wake_latched(o_wake_latched), .o_reset_req(rst_req));
    cpu_side_model #(.OSC_DLY(40), .RET_DLY(10)) model (
        .i_mclk(i_mclk), .i_drop_pin(drop_pin), .i_raise_irq(raise_irq), .i_osc_run(o_osc_run),
        .i_wake_irq(o_wake_irq), .o_pin(pin), .o_osc_stable(stable), .o_irq_return(ret),
        .o_irq_pending(pend));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bust(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= w;
        i_read <= !w;
        do begin
            @(posedge i_mclk);
            n++;
            if (n > 50) begin
                err_count++;
                conclude();
            end
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        e = o_response_err;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        bust(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        bust(1'b0, a, 8'h00, q, e);
        chk(q, exp);
    endtask
    task automatic wait_st(input logic [5:0] s);
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        do begin
            bust(1'b0, OFF_STATUS, 8'h00, q, e);
            n++;
        end while (q[5:0] !== s && n < 200);
        if (q[5:0] !== s) begin
            err_count++;
            conclude();
        end
        chk(q, {26'h0, s});
    endtask
    task automatic rst(input int n);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        repeat (n) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        chk({31'h0, rst_req}, 32'h1);
    endtask
    task automatic ticks(input int span, input int exp);
        int n;
        int m;
        logic p;
        n = 0;
        m = 0;
        repeat (2 * MC_CLKS) @(posedge i_mclk);
        @(negedge i_mclk);
        p = cko;
        repeat (span) begin
            @(negedge i_mclk);
            n += (o_slow_tick === 1'b1);
            m += (cko !== p);
            p = cko;
        end
        chk(n, exp);
        chk(m, exp);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        rdchk(OFF_PWR_CTRL, 32'h0);
        rdchk(OFF_WAKE_CTRL, 32'h0);
        bust(1'b0, 4'h2, 8'h00, q, e);
        chk({31'h0, e}, 32'h1);
        wr(OFF_WAKE_CTRL, 8'h80);
        rdchk(OFF_WAKE_CTRL, 32'h0);
        psb <= 1'b1;
        wr(OFF_PWR_CTRL, 8'h01);
        wr(OFF_PWR_CTRL, 8'h20);
        rdchk(OFF_STATUS, {26'h0, ST_RUN});
        psb <= 1'b0;
    endtask
    task automatic t_idle;
        wr(OFF_PWR_CTRL, 8'h21);
        rdchk(OFF_STATUS, {26'h0, ST_RUN});
        wr(OFF_PWR_CTRL, 8'h01);
        wr(OFF_PWR_CTRL, 8'h20);
        rdchk(OFF_STATUS, {26'h0, ST_IDLE});
        @(negedge i_mclk);
        chk({o_cpu_clk_en, o_periph_clk_en, o_watchdog_run}, 32'h2);
        rdchk(OFF_PWR_CTRL, 32'h0);
        raise_irq <= 1'b1;
        wait_st(ST_RUN);
        raise_irq <= 1'b0;
        wr(OFF_PWR_CTRL, 8'h01);
        wr(OFF_PWR_CTRL, 8'h20);
        rst(2 * MC_CLKS);
        rdchk(OFF_STATUS, {26'h0, ST_RUN});
    endtask
    task automatic t_slow;
        wr(OFF_PWR_CTRL, 8'h10);
        ticks(10 * SLOW_DIV, 10);
        wr(OFF_PWR_CTRL, 8'h11);
        wr(OFF_PWR_CTRL, 8'h30);
        wait_st(ST_IDLE);
        raise_irq <= 1'b1;
        wait_st(ST_RUN);
        raise_irq <= 1'b0;
        rdchk(OFF_PWR_CTRL, 32'h10);
        wr(OFF_PWR_CTRL, 8'h00);
        ticks(64, 64);
    endtask
    task automatic t_pd_reset;
        wr(OFF_PWR_CTRL, 8'h42);
        rdchk(OFF_STATUS, {26'h0, ST_RUN});
        wr(OFF_PWR_CTRL, 8'h03);
        wr(OFF_PWR_CTRL, 8'h60);
        rdchk(OFF_STATUS, {26'h0, ST_PD});
        @(negedge i_mclk);
        chk({o_osc_run, o_strobes_low, o_port_hold}, 32'h3);
        @(posedge i_mclk);
        drop_pin <= 1'b1;
        repeat (40) @(posedge i_mclk);
        drop_pin <= 1'b0;
        rdchk(OFF_STATUS, {26'h0, ST_PD});
        rst(2 * MC_CLKS);
        rdchk(OFF_STATUS, {26'h0, ST_RUN});
        chk({31'h0, o_osc_run}, 32'h1);
    endtask
    task automatic t_pd_wake;
        int n;
        wr(OFF_SYS_CTRL, 8'h10);
        wr(OFF_WAKE_CTRL, 8'h80);
        rdchk(OFF_WAKE_CTRL, 32'h80);
        wr(OFF_SYS_CTRL, 8'h00);
        chk({31'h0, o_irq_global_en}, 32'h0);
        wr(OFF_PWR_CTRL, 8'h02);
        wr(OFF_PWR_CTRL, 8'h40);
        drop_pin <= 1'b1;
        repeat (2) @(posedge i_mclk);
        drop_pin <= 1'b0;
        repeat (20) @(posedge i_mclk);
        rdchk(OFF_STATUS, {26'h0, ST_PD});
        drop_pin <= 1'b1;
        repeat (20) @(posedge i_mclk);
        drop_pin <= 1'b0;
        n = 0;
        while (o_wake_irq !== 1'b1 && n < 300) begin
            @(negedge i_mclk);
            n++;
        end
        if (o_wake_irq !== 1'b1) begin
            err_count++;
            conclude();
        end
        chk({31'h0, o_wake_irq}, 32'h1);
        chk({16'h0, o_wake_vector}, 32'h007b);
        chk({o_timers_frozen, o_irq_global_en, o_wake_latched}, 32'h4);
        wait_st(ST_RUN);
    endtask
    initial begin
        rst(10);
        t_regs();
        t_idle();
        t_slow();
        t_pd_reset();
        t_pd_wake();
        conclude();
    end
endmodule
